// ### src/mbx_device.sv
`timescale 1ns/10ps
// Purpose: Device end that decodes autoconfiguration and name server commands.
// Assumes: Host keeps cmd_valid words back to back; rsp_ready may stall the answer.
// Notes:   Answer carries the fault word in extended word 8 and echoes data.
module mbx_device
    import mbx_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rstn,
    mbx_if.device            mbx,
    input  wire logic        init_done,
    output logic             autoconf_en,
    output logic             web_autoconf_show,
    output logic             discovery_status_en,
    output logic [31:0]      primary_server,
    output logic [31:0]      secondary_server,
    output logic             secondary_used,
    output logic             cmd_seen
);
    typedef enum logic [1:0] {
        D_RECV = 2'b00,
        D_RESP = 2'b01,
        D_SKIP = 2'b10
    } dstate_e;

    typedef struct packed {
        dstate_e     st;
        logic [4:0]  idx;
        logic [15:0] id;
        logic [15:0] cmd;
        logic [15:0] size;
        logic        bad;
        logic [63:0] dat;
        logic        en;
        logic [31:0] pri;
        logic [31:0] sec;
        logic        rv;
        logic [15:0] rw;
        logic        rl;
        logic        seen;
    } dregs_s;

    dregs_s r;
    dregs_s next_r;
    logic [4:0]  nwords;
    logic [15:0] rword;
    logic [4:0]  didx;
    logic        ok;

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        nwords = (r.cmd == name_server_load_cmd) ? NAME_SRV_WORDS : ZERO5;
        ok = !r.bad && !init_done;
        didx = r.idx - HDR_WORDS;
        case (r.idx)
            HDR_ID:     rword = r.id;
            HDR_INFO:   rword = ok ? MSG_INFO_RSP : MSG_INFO_ERR;
            HDR_CMD:    rword = r.cmd;
            HDR_SIZE:   rword = r.size;
            HDR_FCOUNT: rword = FRAME_ONE;
            HDR_FNUM:   rword = FRAME_ONE;
            HDR_EXT8:   rword = ok ? FAULT_NONE : FAULT_REJECT;
            default: begin
                if (r.idx >= HDR_WORDS) begin
                    rword = r.dat[63 - 16*didx[1:0] -: 16];
                end else begin
                    rword = WORD_ZERO;
                end
            end
        endcase
    end

    always_comb begin
        next_r = r;
        next_r.seen = 1'b0;
        case (r.st)
            D_RECV: begin
                next_r.rv = 1'b0;
                next_r.rl = 1'b0;
                if (mbx.cmd_valid) begin
                    next_r.idx = r.idx + ONE5;
                    case (r.idx)
                        HDR_ID:     next_r.id = mbx.cmd_word;
                        HDR_INFO:   next_r.bad = (mbx.cmd_word != MSG_INFO_CMD);
                        HDR_CMD:    next_r.cmd = mbx.cmd_word;
                        HDR_SIZE:   next_r.size = mbx.cmd_word;
                        HDR_FCOUNT: next_r.bad = r.bad | (mbx.cmd_word != FRAME_ONE);
                        HDR_FNUM:   next_r.bad = r.bad | (mbx.cmd_word != FRAME_ONE);
                        HDR_OFFH:   next_r.bad = r.bad | (mbx.cmd_word != WORD_ZERO);
                        HDR_OFFL:   next_r.bad = r.bad | (mbx.cmd_word != WORD_ZERO);
                        default: begin
                            if (r.idx >= HDR_WORDS) begin
                                next_r.dat = {r.dat[47:0], mbx.cmd_word};
                            end
                        end
                    endcase
                    if (r.idx == HDR_SIZE) begin
                        if (r.cmd == name_server_load_cmd) begin
                            next_r.bad = r.bad | (mbx.cmd_word != SIZE_NAME_SRV);
                        end else if (r.cmd == autoconf_off_cmd || r.cmd == autoconf_on_cmd) begin
                            next_r.bad = r.bad | (mbx.cmd_word != SIZE_NONE);
                        end else begin
                            next_r.bad = 1'b1;
                        end
                    end
                    if (mbx.cmd_last) begin
                        next_r.idx = ZERO5;
                        next_r.st = D_RESP;
                        next_r.seen = 1'b1;
                        if (r.idx != HDR_WORDS + nwords - ONE5) begin
                            next_r.bad = 1'b1;
                        end
                    end
                end
            end
            D_RESP: begin
                if (r.idx == ZERO5 && !r.rv) begin
                    if (ok) begin
                        if (r.cmd == autoconf_off_cmd) begin
                            next_r.en = 1'b0;
                        end else if (r.cmd == autoconf_on_cmd) begin
                            next_r.en = 1'b1;
                        end else begin
                            next_r.pri = r.dat[63:32];
                            next_r.sec = r.dat[31:0];
                        end
                    end
                    next_r.rv = 1'b1;
                    next_r.rw = rword;
                    next_r.rl = 1'b0;
                end else if (mbx.rsp_ready) begin
                    if (r.rl) begin
                        next_r.rv = 1'b0;
                        next_r.rl = 1'b0;
                        next_r.idx = ZERO5;
                        next_r.bad = 1'b0;
                        next_r.st = D_RECV;
                    end else begin
                        next_r.idx = r.idx + ONE5;
                        next_r.rw = (r.idx + ONE5 == HDR_INFO) ? (ok ? MSG_INFO_RSP : MSG_INFO_ERR)
                                  : WORD_ZERO;
                        next_r.rl = (r.idx + ONE5 == HDR_WORDS + nwords - ONE5);
                    end
                end
                if (r.rv && mbx.rsp_ready && !r.rl) begin
                    next_r.rw = word_at(r.idx + ONE5);
                end
            end
            default: next_r.st = D_RECV;
        endcase
    end

    function automatic logic [15:0] word_at(input logic [4:0] i);
        logic [4:0] d;
        d = i - HDR_WORDS;
        case (i)
            HDR_ID:     word_at = r.id;
            HDR_INFO:   word_at = ok ? MSG_INFO_RSP : MSG_INFO_ERR;
            HDR_CMD:    word_at = r.cmd;
            HDR_SIZE:   word_at = r.size;
            HDR_FCOUNT: word_at = FRAME_ONE;
            HDR_FNUM:   word_at = FRAME_ONE;
            HDR_EXT8:   word_at = ok ? FAULT_NONE : FAULT_REJECT;
            default:    word_at = (i >= HDR_WORDS) ? r.dat[63 - 16*d[1:0] -: 16] : WORD_ZERO;
        endcase
    endfunction

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            autoconf_en <= 1'b0;
            web_autoconf_show <= 1'b0;
            discovery_status_en <= 1'b0;
            primary_server <= '0;
            secondary_server <= '0;
            secondary_used <= 1'b0;
            cmd_seen <= 1'b0;
        end else begin
            autoconf_en <= next_r.en;
            web_autoconf_show <= next_r.en;
            discovery_status_en <= next_r.en;
            primary_server <= next_r.pri;
            secondary_server <= next_r.sec;
            secondary_used <= (next_r.sec != '0);
            cmd_seen <= next_r.seen;
        end
    end

    assign mbx.rsp_valid = r.rv;
    assign mbx.rsp_word = r.rw;
    assign mbx.rsp_last = r.rl;
endmodule

// ### src/mbx_pkg.sv
// Purpose: Shared constants for the network configuration mailbox command path.
// Assumes: One 16-bit word moves per valid cycle for commands, and per valid and ready cycle for answers.
// Notes:   Frames are header words then data words; the answer uses the same layout.
//
// What this block does
// - Off command clears autoconfiguration, no data.
// - On command sets autoconfiguration, no data.
// - Autoconfiguration off from reset until enabled.
// - Host sends these only during initialization.
// - Autoconfiguration off hides web and discovery status.
// - Autoconfiguration on shows web and discovery status.
// - Every command gets an accept or reject answer.
// - Name server load carries four words, eight bytes.
// - First two data words form primary server.
// - Zero secondary means primary server only.
// - Name server load echoes its four words.
package mbx_pkg;
    localparam logic [15:0] autoconf_off_cmd     = 16'h0015;
    localparam logic [15:0] autoconf_on_cmd      = 16'h001a;
    localparam logic [15:0] name_server_load_cmd = 16'h0031;
    localparam logic [15:0] MSG_INFO_CMD         = 16'h4002;
    localparam logic [15:0] MSG_INFO_RSP         = 16'h0002;
    localparam logic [15:0] MSG_INFO_ERR         = 16'h8002;
    localparam logic [15:0] SIZE_NONE            = 16'h0000;
    localparam logic [15:0] SIZE_NAME_SRV        = 16'h0008;
    localparam logic [15:0] FRAME_ONE            = 16'h0001;
    localparam logic [15:0] WORD_ZERO            = 16'h0000;
    localparam logic [15:0] FAULT_NONE           = 16'h0000;
    localparam logic [15:0] FAULT_REJECT         = 16'h0001;
    localparam logic [4:0]  HDR_WORDS            = 5'h10;
    localparam logic [4:0]  HDR_ID               = 5'h00;
    localparam logic [4:0]  HDR_INFO             = 5'h01;
    localparam logic [4:0]  HDR_CMD              = 5'h02;
    localparam logic [4:0]  HDR_SIZE             = 5'h03;
    localparam logic [4:0]  HDR_FCOUNT           = 5'h04;
    localparam logic [4:0]  HDR_FNUM             = 5'h05;
    localparam logic [4:0]  HDR_OFFH             = 5'h06;
    localparam logic [4:0]  HDR_OFFL             = 5'h07;
    localparam logic [4:0]  HDR_EXT8             = 5'h0f;
    localparam logic [4:0]  NAME_SRV_WORDS       = 5'h04;
    localparam logic [4:0]  ZERO5                = 5'h00;
    localparam logic [4:0]  ONE5                 = 5'h01;
endpackage

// ### src/mbx_if.sv
`timescale 1ns/10ps
// Purpose: Mailbox link between host and device, one word per beat each way.
// Assumes: Shared clock mclk; last marks the final word of a message.
// Notes:   Commands flow host to device, answers device to host.
interface mbx_if;
    logic        cmd_valid;
    logic [15:0] cmd_word;
    logic        cmd_last;
    logic        rsp_valid;
    logic [15:0] rsp_word;
    logic        rsp_last;
    logic        rsp_ready;
    modport device (input cmd_valid, input cmd_word, input cmd_last, input rsp_ready,
                    output rsp_valid, output rsp_word, output rsp_last);
    modport host   (output cmd_valid, output cmd_word, output cmd_last, output rsp_ready,
                    input rsp_valid, input rsp_word, input rsp_last);
endinterface

// ### src/mbx_host.sv
`timescale 1ns/10ps
// Purpose: Host end that sends one configuration command and collects the answer.
// Assumes: User raises start for one cycle while idle.
// Notes:   Builds a single-frame message with fixed header words.
module mbx_host
    import mbx_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rstn,
    mbx_if.host              mbx,
    input  wire logic        start,
    input  wire logic [15:0] cmd_code,
    input  wire logic [15:0] msg_id,
    input  wire logic [63:0] send_data,
    input  wire logic        init_phase,
    output logic             busy,
    output logic             done,
    output logic             accepted,
    output logic [63:0]      echo_data,
    output logic             not_sent
);
    typedef enum logic [1:0] {
        H_IDLE = 2'b00,
        H_SEND = 2'b01,
        H_WAIT = 2'b10
    } hstate_e;

    typedef struct packed {
        hstate_e     st;
        logic [4:0]  idx;
        logic [4:0]  nwords;
        logic [15:0] cmd;
        logic [15:0] id;
        logic [63:0] dat;
        logic [4:0]  ridx;
        logic        acc;
        logic [63:0] echo;
        logic        done;
        logic        nsent;
    } hregs_s;

    hregs_s r;
    hregs_s next_r;
    logic [15:0] word;
    logic [4:0]  didx;

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        didx = r.idx - HDR_WORDS;
        case (r.idx)
            HDR_ID:     word = r.id;
            HDR_INFO:   word = MSG_INFO_CMD;
            HDR_CMD:    word = r.cmd;
            HDR_SIZE:   word = (r.nwords == ZERO5) ? SIZE_NONE : SIZE_NAME_SRV;
            HDR_FCOUNT: word = FRAME_ONE;
            HDR_FNUM:   word = FRAME_ONE;
            default: begin
                if (r.idx >= HDR_WORDS) begin
                    word = r.dat[63 - 16*didx[1:0] -: 16];
                end else begin
                    word = WORD_ZERO;
                end
            end
        endcase
    end

    always_comb begin
        next_r = r;
        next_r.done = 1'b0;
        next_r.nsent = 1'b0;
        case (r.st)
            H_IDLE: begin
                if (start && !init_phase) begin
                    next_r.nsent = 1'b1;
                end else if (start) begin
                    next_r.st = H_SEND;
                    next_r.idx = ZERO5;
                    next_r.cmd = cmd_code;
                    next_r.id = msg_id;
                    next_r.dat = send_data;
                    next_r.nwords = (cmd_code == name_server_load_cmd) ? NAME_SRV_WORDS : ZERO5;
                end
            end
            H_SEND: begin
                next_r.idx = r.idx + ONE5;
                if (r.idx == HDR_WORDS + r.nwords - ONE5) begin
                    next_r.st = H_WAIT;
                    next_r.ridx = ZERO5;
                end
            end
            H_WAIT: begin
                if (mbx.rsp_valid && mbx.rsp_ready) begin
                    next_r.ridx = r.ridx + ONE5;
                    if (r.ridx == HDR_EXT8) begin
                        next_r.acc = (mbx.rsp_word == FAULT_NONE);
                    end
                    if (r.ridx >= HDR_WORDS) begin
                        next_r.echo = {r.echo[47:0], mbx.rsp_word};
                    end
                    if (mbx.rsp_last) begin
                        next_r.st = H_IDLE;
                        next_r.done = 1'b1;
                    end
                end
            end
            default: next_r.st = H_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    logic        o_valid;
    logic [15:0] o_word;
    logic        o_last;
    logic        o_ready;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            o_valid <= 1'b0;
            o_word <= '0;
            o_last <= 1'b0;
            o_ready <= 1'b1;
        end else begin
            o_valid <= (r.st == H_SEND);
            o_word <= word;
            o_last <= (r.st == H_SEND) && (r.idx == HDR_WORDS + r.nwords - ONE5);
            // Ready drops every other waiting cycle, so the answer side sees stalls.
            o_ready <= (r.st == H_WAIT) ? ~o_ready : 1'b1;
        end
    end

    assign mbx.cmd_valid = o_valid;
    assign mbx.cmd_word = o_word;
    assign mbx.cmd_last = o_last;
    assign mbx.rsp_ready = o_ready;
    assign busy = (r.st != H_IDLE);
    assign done = r.done;
    assign accepted = r.acc;
    assign echo_data = r.echo;
    assign not_sent = r.nsent;
endmodule

// ### testbench/mbx_link_props.sv
// Purpose: Checks on the mailbox link and the device settings.
// Assumes: One clock domain, reset active low.
// Notes:   Instantiated beside the link that joins the two ends.
`timescale 1ns/10ps
module mbx_link_props
    import mbx_pkg::*;
(
    input wire logic        mclk,
    input wire logic        rstn,
    input wire logic        cmd_valid,
    input wire logic        cmd_last,
    input wire logic        rsp_valid,
    input wire logic [15:0] rsp_word,
    input wire logic        rsp_last,
    input wire logic        rsp_ready,
    input wire logic        init_done,
    input wire logic        autoconf_en,
    input wire logic        web_autoconf_show,
    input wire logic        discovery_status_en,
    input wire logic [31:0] secondary_server,
    input wire logic        secondary_used
);
    ////////////////////////////////////////////////////////////////////////////////
    // Counts answer words taken by the host.
    logic [4:0] idx;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            idx <= 5'h00;
        end else if (rsp_valid && rsp_ready) begin
            idx <= rsp_last ? 5'h00 : idx + 5'h01;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////////////////////
    sequence s_beat(logic [4:0] n);
        rsp_valid && rsp_ready && idx == n;
    endsequence
    property p_rst; $rose(rstn) |-> !autoconf_en; endproperty
    property p_mirror;
        web_autoconf_show == autoconf_en && discovery_status_en == autoconf_en;
    endproperty
    property p_sec; secondary_used == (secondary_server != 32'h0); endproperty
    property p_hold;
        rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_word) && $stable(rsp_last);
    endproperty
    property p_answer; cmd_valid && cmd_last |-> ##2 rsp_valid; endproperty
    property p_info;
        s_beat(HDR_INFO) |-> rsp_word == MSG_INFO_RSP || rsp_word == MSG_INFO_ERR;
    endproperty
    property p_late; s_beat(HDR_INFO) ##0 init_done |-> rsp_word == MSG_INFO_ERR; endproperty
    property p_frame; s_beat(HDR_FCOUNT) |-> rsp_word == FRAME_ONE; endproperty
    property p_offs; s_beat(HDR_OFFH) |-> rsp_word == WORD_ZERO; endproperty
    property p_locked; init_done && $past(init_done) |-> $stable(autoconf_en); endproperty
    property p_move; $changed(autoconf_en) |-> ##[0:2] rsp_valid; endproperty
    a_rst: assert property (p_rst) else $error("autoconf on at reset release");
    a_mirror: assert property (p_mirror) else $error("status outputs differ");
    a_sec: assert property (p_sec) else $error("secondary use flag wrong");
    a_hold: assert property (p_hold) else $error("answer word moved while stalled");
    a_answer: assert property (p_answer) else $error("answer not started");
    a_info: assert property (p_info) else $error("bad answer info word");
    a_late: assert property (p_late) else $error("late command not rejected");
    a_frame: assert property (p_frame) else $error("frame count not one");
    a_offs: assert property (p_offs) else $error("offset word not zero");
    a_locked: assert property (p_locked) else $error("setting moved after init");
    a_move: assert property (p_move) else $error("setting moved without answer");
endmodule

// ### testbench/network_config_mailbox_cmds_bench.sv
// Purpose: Self-checking bench joining host and device over the link.
// Assumes: Both ends run on mclk at 250 MHz.
// Notes:   A second device takes malformed frames from a bench driver.
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; \
    $display("[ERR] %0t mismatch %h %h", $time, a, b); end end
module network_config_mailbox_cmds_bench
    import mbx_pkg::*;
;
    logic        mclk, rstn, start, init_phase, init_done, busy, done, accepted, not_sent;
    logic        autoconf_en, web_autoconf_show, discovery_status_en, secondary_used;
    logic        cmd_seen, auto_b, exp_auto, bdone;
    logic [15:0] cmd_code, msg_id, binfo;
    logic [63:0] send_data, echo_data;
    logic [31:0] primary_server, secondary_server, exp_pri, exp_sec;
    logic [15:0] rsp [0:19];
    logic [15:0] cw  [0:19];
    logic [15:0] cmds [0:2] = '{autoconf_off_cmd, autoconf_on_cmd, name_server_load_cmd};
    logic [7:0]  r;
    int          seed, ri, ci, bi, num_errors, checked, seen_n;
    mbx_if link();
    mbx_if link_b();
    mbx_host i_mbx_host (.mclk(mclk), .rstn(rstn), .mbx(link), .start(start),
        .cmd_code(cmd_code), .msg_id(msg_id), .send_data(send_data), .init_phase(init_phase),
        .busy(busy), .done(done), .accepted(accepted), .echo_data(echo_data),
        .not_sent(not_sent));
    mbx_device i_mbx_device (.mclk(mclk), .rstn(rstn), .mbx(link), .init_done(init_done),
        .autoconf_en(autoconf_en), .web_autoconf_show(web_autoconf_show),
        .discovery_status_en(discovery_status_en), .primary_server(primary_server),
        .secondary_server(secondary_server), .secondary_used(secondary_used),
        .cmd_seen(cmd_seen));
    mbx_device i_mbx_device_b (.mclk(mclk), .rstn(rstn), .mbx(link_b), .init_done(1'b0),
        .autoconf_en(auto_b), .web_autoconf_show(), .discovery_status_en(),
        .primary_server(), .secondary_server(), .secondary_used(), .cmd_seen());
    mbx_link_props i_mbx_link_props (.mclk(mclk), .rstn(rstn), .cmd_valid(link.cmd_valid),
        .cmd_last(link.cmd_last), .rsp_valid(link.rsp_valid), .rsp_word(link.rsp_word),
        .rsp_last(link.rsp_last), .rsp_ready(link.rsp_ready), .init_done(init_done),
        .autoconf_en(autoconf_en), .web_autoconf_show(web_autoconf_show),
        .discovery_status_en(discovery_status_en), .secondary_server(secondary_server),
        .secondary_used(secondary_used));
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        if (link.rsp_valid && link.rsp_ready && ri < 20) begin
            rsp[ri] <= link.rsp_word;
            ri <= ri + 1;
        end
        if (cmd_seen) seen_n <= seen_n + 1;
        if (link.cmd_valid && ci < 20) begin
            cw[ci] <= link.cmd_word;
            ci <= ci + 1;
        end
        if (link_b.rsp_valid && link_b.rsp_ready) begin
            if (bi == 1) binfo <= link_b.rsp_word;
            bi <= link_b.rsp_last ? 0 : bi + 1;
            if (link_b.rsp_last) bdone <= 1'b1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] info_of(input logic ok);
        return ok ? MSG_INFO_RSP : MSG_INFO_ERR;
    endfunction
    task automatic tally_and_finish();
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic run(input logic [15:0] cmd, input logic [63:0] data, input logic ok);
        logic is_ns;
        int   n;
        int   s0;
        is_ns = (cmd == name_server_load_cmd);
        @(negedge mclk);
        ri = 0;
        ci = 0;
        cmd_code = cmd;
        send_data = data;
        msg_id = 16'($random(seed));
        s0 = seen_n;
        start = 1'b1;
        @(negedge mclk);
        start = 1'b0;
        `CHK(busy, 1'b1)
        n = 0;
        while (done !== 1'b1 && n < 300) begin
            @(negedge mclk);
            n++;
        end
        `CHK(done, 1'b1)
        `CHK(busy, 1'b0)
        `CHK(seen_n, s0 + 1)
        `CHK(accepted, ok)
        `CHK(cw[HDR_INFO], MSG_INFO_CMD)
        `CHK(cw[HDR_SIZE], is_ns ? SIZE_NAME_SRV : SIZE_NONE)
        `CHK(rsp[HDR_ID], msg_id)
        `CHK(rsp[HDR_INFO], info_of(ok))
        `CHK(rsp[HDR_CMD], cmd)
        `CHK(rsp[HDR_FCOUNT], FRAME_ONE)
        `CHK(rsp[HDR_OFFL], WORD_ZERO)
        `CHK(rsp[HDR_EXT8], ok ? FAULT_NONE : FAULT_REJECT)
        if (ok && cmd == autoconf_off_cmd) exp_auto = 1'b0;
        if (ok && cmd == autoconf_on_cmd) exp_auto = 1'b1;
        if (ok && is_ns) begin
            exp_pri = data[63:32];
            exp_sec = data[31:0];
            for (int k = 0; k < 4; k++) `CHK(rsp[16+k], data[63-16*k -: 16])
            `CHK(echo_data, data)
        end
        `CHK(autoconf_en, exp_auto)
        `CHK({web_autoconf_show, discovery_status_en}, {2{exp_auto}})
        `CHK(primary_server, exp_pri)
        `CHK(secondary_server, exp_sec)
        `CHK(secondary_used, exp_sec != 32'h0)
    endtask
    task automatic bad_frame(input logic [15:0] size, input logic [15:0] fcount);
        int n;
        bdone = 1'b0;
        for (int k = 0; k < 16; k++) begin
            @(negedge mclk);
            link_b.cmd_valid = 1'b1;
            link_b.cmd_word = k == 1 ? MSG_INFO_CMD : k == 2 ? autoconf_on_cmd :
                k == 3 ? size : k == 4 ? fcount : k == 5 ? FRAME_ONE : WORD_ZERO;
            link_b.cmd_last = (k == 15);
        end
        @(negedge mclk);
        link_b.cmd_valid = 1'b0;
        link_b.cmd_last = 1'b0;
        n = 0;
        while (bdone !== 1'b1 && n < 100) begin
            @(negedge mclk);
            link_b.rsp_ready = 1'($random(seed));
            n++;
        end
        link_b.rsp_ready = 1'b1;
        `CHK(binfo, info_of(size == SIZE_NONE && fcount == FRAME_ONE))
        `CHK(auto_b, size == SIZE_NONE && fcount == FRAME_ONE)
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        // Run takes about 5 us; the span leaves ample margin.
        #100000;
        num_errors++;
        tally_and_finish();
    end
    initial begin
        seed = 29698;
        {rstn, start, init_done, exp_auto, bdone} = 5'h00;
        init_phase = 1'b1;
        {cmd_code, msg_id, send_data, exp_pri, exp_sec} = '0;
        {ri, ci, bi, num_errors, checked, seen_n} = '0;
        {link_b.cmd_valid, link_b.cmd_last, link_b.cmd_word} = '0;
        link_b.rsp_ready = 1'b1;
        repeat (16) @(negedge mclk);
        `CHK(autoconf_en, 1'b0)
        rstn = 1'b1;
        @(negedge mclk);
        `CHK(autoconf_en, 1'b0)
        run(autoconf_off_cmd, 64'h0, 1'b1);
        run(autoconf_on_cmd, 64'h0, 1'b1);
        run(autoconf_on_cmd, 64'h0, 1'b1);
        run(name_server_load_cmd, {32'hffffffff, 32'h0}, 1'b1);
        repeat (12) begin
            r = 8'($random(seed));
            run(cmds[r % 3], {$random(seed), $random(seed)}, 1'b1);
        end
        bad_frame(16'h0001, FRAME_ONE);
        bad_frame(SIZE_NONE, 16'h0002);
        bad_frame(SIZE_NONE, FRAME_ONE);
        init_done = 1'b1;
        run(autoconf_off_cmd, 64'h0, 1'b0);
        run(autoconf_on_cmd, 64'h0, 1'b0);
        run(name_server_load_cmd, {$random(seed), $random(seed)}, 1'b0);
        @(negedge mclk);
        ci = 0;
        init_phase = 1'b0;
        start = 1'b1;
        @(negedge mclk);
        `CHK(not_sent, 1'b1)
        `CHK(busy, 1'b0)
        start = 1'b0;
        repeat (20) @(negedge mclk);
        `CHK(ci == 0, 1'b1)
        tally_and_finish();
    end
endmodule
